// ### logic/aircr_pkg.sv
// Package for the input and rate configuration register bank
package aircr_pkg;
	// Register indices on the command port
	localparam logic [1:0] REG_INPUT_GAIN = 2'h0;
	localparam logic [1:0] REG_RATE_MODE = 2'h1;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Input and gain register fields
	localparam int SEL_HI = 7;
	localparam int SEL_LO = 4;
	localparam int GAIN_HI = 3;
	localparam int GAIN_LO = 1;
	localparam int BYPASS_BIT = 0;
	// Rate and mode register fields
	localparam int RATE_HI = 7;
	localparam int RATE_LO = 5;
	localparam int MODE_HI = 4;
	localparam int MODE_LO = 3;
	localparam int CONV_BIT = 2;
	localparam int TEMP_BIT = 1;
	localparam int BURN_BIT = 0;
	// Selector codes
	localparam logic [3:0] SEL_GND_FIRST = 4'h8;
	localparam logic [3:0] SEL_GND_LAST = 4'hB;
	localparam logic [3:0] SEL_REF_MON = 4'hC;
	localparam logic [3:0] SEL_SUP_MON = 4'hD;
	localparam logic [3:0] SEL_MID_MON = 4'hE;
	localparam logic [3:0] SEL_RESERVED = 4'hF;
	// Highest gain code that may run without the amplifier (gain 4)
	localparam logic [2:0] GAIN_MAX_BYPASS = 3'h2;
	// Negative input code meaning analog ground
	localparam logic [2:0] NEG_GROUND = 3'h4;
	localparam logic [2:0] RATE_RESERVED = 3'h7;

	// Operating modes
	typedef enum logic [1:0] {
		AIRCR_NORMAL,
		AIRCR_DUTY,
		AIRCR_TURBO,
		AIRCR_MODE_RSVD
	} aircr_mode_e;

	// Monitor selections
	typedef enum logic [1:0] {
		AIRCR_MON_NONE,
		AIRCR_MON_REF,
		AIRCR_MON_SUPPLY,
		AIRCR_MON_MID
	} aircr_mon_e;

	// Decoded controls handed to the converter
	typedef struct packed {
		logic [1:0] pos_input;
		logic [2:0] neg_input;
		aircr_mon_e monitor;
		logic sel_reserved;
		logic [2:0] gain_log2;
		logic amp_bypass_eff;
		logic [2:0] rate_code;
		logic [17:0] rate_centi_sps;
		aircr_mode_e mode;
		logic mod_clk_fast;
		logic duty_cycle;
		logic conversion_mode;
		logic temp_sensor_enable;
		logic ref_internal_forced;
		logic burnout_source_enable;
	} aircr_ctrl_s;
endpackage : aircr_pkg

// ### logic/aircr_regs.sv
// Input, gain, rate and mode configuration registers with control decode
// Contract
// - Bits 7-4 of the input register select twelve input pairings or a monitor, 0000 default, 1111 reserved.
// - Bits 3-1 of the input register give a gain of two to the power of the code, 1 to 128.
// - Bit 0 of the input register set to 1 disables and bypasses the amplifier, 0 keeps it on.
// - The amplifier stays on for gains 8 to 128 whatever the bypass bit says.
// - Bits 7-5 of the rate register hold a rate code whose rate depends on the operating mode.
// - Bits 4-3 select normal, duty-cycle, turbo or a reserved mode.
// - Bit 2 selects single-shot (0) or continuous (1) conversion.
// - Bit 1 enters temperature-sensor mode, ignoring the input register and forcing the internal reference.
// - Bit 0 switches the burn-out current sources on (1) or off (0).
// - All fields read and write and reset to zero.
// - A configuration write updates the registers only at the final clock edge of the command.
// - After a configuration write the filter resets and conversion restarts with the new settings.
// - Registers keep their values in power-down and clear only on power-up or reset.
// - Rate codes give fixed rates at the nominal clock and scale with any other external clock.
`timescale 1ns/1ps

module aircr_regs (
	input wire logic sys_clk, // System clock, 100 MHz
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire logic wr_stage, // Pulse: a data byte of a write command arrived
	input wire logic [1:0] wr_addr, // Register index of the staged byte
	input wire logic [7:0] wr_data, // Staged byte
	input wire logic wr_commit, // Pulse: final clock edge of the write command
	input wire logic rd_req, // Pulse: read command wants a byte
	input wire logic [1:0] rd_addr, // Register index to read
	output logic [7:0] rd_data, // Read byte
	output logic rd_valid, // Pulse: rd_data is valid
	output aircr_pkg::aircr_ctrl_s ctrl, // Decoded converter controls
	output logic filter_restart // Pulse: reset filter, restart conversion
);

	////////////////////////////////////////////////////////////////////////
	// Selector decode: positive input, negative input, monitor
	function automatic logic [6:0] sel_decode(input logic [3:0] sel);
		logic [1:0] p;
		logic [2:0] n;
		aircr_pkg::aircr_mon_e m;
		p = 2'h0;
		n = 3'h1;
		m = aircr_pkg::AIRCR_MON_NONE;
		case (sel)
			4'h0:
			begin
				p = 2'h0;
				n = 3'h1;
			end
			4'h1:
			begin
				p = 2'h0;
				n = 3'h2;
			end
			4'h2:
			begin
				p = 2'h0;
				n = 3'h3;
			end
			4'h3:
			begin
				p = 2'h1;
				n = 3'h2;
			end
			4'h4:
			begin
				p = 2'h1;
				n = 3'h3;
			end
			4'h5:
			begin
				p = 2'h2;
				n = 3'h3;
			end
			4'h6:
			begin
				p = 2'h1;
				n = 3'h0;
			end
			4'h7:
			begin
				p = 2'h3;
				n = 3'h2;
			end
			4'h8, 4'h9, 4'hA, 4'hB:
			begin
				p = sel[1:0];
				n = aircr_pkg::NEG_GROUND;
			end
			aircr_pkg::SEL_REF_MON:
			begin
				m = aircr_pkg::AIRCR_MON_REF;
			end
			aircr_pkg::SEL_SUP_MON:
			begin
				m = aircr_pkg::AIRCR_MON_SUPPLY;
			end
			aircr_pkg::SEL_MID_MON:
			begin
				m = aircr_pkg::AIRCR_MON_MID;
			end
			// Reserved code keeps the first pairing and no monitor
			default:
			begin
				m = aircr_pkg::AIRCR_MON_NONE;
			end
		endcase
		return {p, n, m};
	endfunction : sel_decode

	////////////////////////////////////////////////////////////////////////
	// Nominal rate in hundredths of a sample per second at the nominal clock
	function automatic logic [17:0] rate_lookup(input logic [1:0] mode, input logic [2:0] code);
		logic [17:0] r;
		r = 18'h0_0000;
		case (mode)
			// Normal mode
			aircr_pkg::AIRCR_NORMAL:
			begin
				case (code)
					3'h0: r = 18'd2000;
					3'h1: r = 18'd4500;
					3'h2: r = 18'd9000;
					3'h3: r = 18'd17500;
					3'h4: r = 18'd33000;
					3'h5: r = 18'd60000;
					3'h6: r = 18'd100000;
					default: r = 18'h0_0000;
				endcase
			end
			// Duty-cycle mode, a quarter of normal except code 3 (4400 against 4375)
			aircr_pkg::AIRCR_DUTY:
			begin
				case (code)
					3'h0: r = 18'd500;
					3'h1: r = 18'd1125;
					3'h2: r = 18'd2250;
					3'h3: r = 18'd4400;
					3'h4: r = 18'd8250;
					3'h5: r = 18'd15000;
					3'h6: r = 18'd25000;
					default: r = 18'h0_0000;
				endcase
			end
			// Turbo mode, twice normal
			aircr_pkg::AIRCR_TURBO:
			begin
				case (code)
					3'h0: r = 18'd4000;
					3'h1: r = 18'd9000;
					3'h2: r = 18'd18000;
					3'h3: r = 18'd35000;
					3'h4: r = 18'd66000;
					3'h5: r = 18'd120000;
					3'h6: r = 18'd200000;
					default: r = 18'h0_0000;
				endcase
			end
			default: r = 18'h0_0000;
		endcase
		return r;
	endfunction : rate_lookup

	////////////////////////////////////////////////////////////////////////
	// Full control decode of both stored bytes
	function automatic aircr_pkg::aircr_ctrl_s ctrl_decode(input logic [7:0] in_reg, input logic [7:0] rate_reg);
		aircr_pkg::aircr_ctrl_s c;
		logic [3:0] sel;
		logic [2:0] gain;
		logic byp;
		logic [2:0] rate;
		logic [1:0] mode;
		logic temp;
		logic [6:0] dec;
		sel = in_reg[aircr_pkg::SEL_HI:aircr_pkg::SEL_LO];
		gain = in_reg[aircr_pkg::GAIN_HI:aircr_pkg::GAIN_LO];
		byp = in_reg[aircr_pkg::BYPASS_BIT];
		rate = rate_reg[aircr_pkg::RATE_HI:aircr_pkg::RATE_LO];
		mode = rate_reg[aircr_pkg::MODE_HI:aircr_pkg::MODE_LO];
		temp = rate_reg[aircr_pkg::TEMP_BIT];
		// Input settings count only outside temperature-sensor mode
		dec = sel_decode(temp ? 4'h0 : sel);
		c.pos_input = dec[6:5];
		c.neg_input = dec[4:2];
		c.monitor = aircr_pkg::aircr_mon_e'(dec[1:0]);
		c.sel_reserved = !temp && (sel == aircr_pkg::SEL_RESERVED);
		c.gain_log2 = temp ? 3'h0 : gain;
		c.amp_bypass_eff = !temp && byp && (gain <= aircr_pkg::GAIN_MAX_BYPASS);
		c.rate_code = rate;
		c.rate_centi_sps = rate_lookup(mode, rate);
		c.mode = aircr_pkg::aircr_mode_e'(mode);
		c.mod_clk_fast = (mode == aircr_pkg::AIRCR_TURBO);
		c.duty_cycle = (mode == aircr_pkg::AIRCR_DUTY);
		c.conversion_mode = rate_reg[aircr_pkg::CONV_BIT];
		c.temp_sensor_enable = temp;
		c.ref_internal_forced = temp;
		c.burnout_source_enable = rate_reg[aircr_pkg::BURN_BIT];
		return c;
	endfunction : ctrl_decode

	// Controls of the reset bytes, so the outputs do not jump after reset
	localparam aircr_pkg::aircr_ctrl_s CTRL_RESET = ctrl_decode(aircr_pkg::REG_RESET, aircr_pkg::REG_RESET);

	////////////////////////////////////////////////////////////////////////
	// Stored bytes, staged bytes and pending flags
	logic [7:0] in_reg_q;
	logic [7:0] rate_reg_q;
	logic [7:0] in_stage_q;
	logic [7:0] rate_stage_q;
	logic in_pend_q;
	logic rate_pend_q;
	logic commit_dly_q;
	logic [7:0] rd_data_q;
	logic rd_valid_q;
	aircr_pkg::aircr_ctrl_s ctrl_q;
	aircr_pkg::aircr_ctrl_s ctrl_d;

	// Staging strobes per register
	wire stage_in = wr_stage && (wr_addr == aircr_pkg::REG_INPUT_GAIN);
	wire stage_rate = wr_stage && (wr_addr == aircr_pkg::REG_RATE_MODE);
	// Bytes and flags that the commit will use, including one staged this cycle
	wire [7:0] in_stage_d = stage_in ? wr_data : in_stage_q;
	wire [7:0] rate_stage_d = stage_rate ? wr_data : rate_stage_q;
	wire in_pend_d = stage_in || in_pend_q;
	wire rate_pend_d = stage_rate || rate_pend_q;

	// Stage bytes; commit them together at the end of the command
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			in_reg_q <= aircr_pkg::REG_RESET;
			rate_reg_q <= aircr_pkg::REG_RESET;
			in_stage_q <= aircr_pkg::REG_RESET;
			rate_stage_q <= aircr_pkg::REG_RESET;
			in_pend_q <= 1'b0;
			rate_pend_q <= 1'b0;
		end
		else
		begin
			in_stage_q <= in_stage_d;
			rate_stage_q <= rate_stage_d;
			in_pend_q <= in_pend_d && !wr_commit;
			rate_pend_q <= rate_pend_d && !wr_commit;
			if (wr_commit && in_pend_d)
			begin
				in_reg_q <= in_stage_d;
			end
			if (wr_commit && rate_pend_d)
			begin
				rate_reg_q <= rate_stage_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded control next value from the stored bytes
	assign ctrl_d = ctrl_decode(in_reg_q, rate_reg_q);

	////////////////////////////////////////////////////////////////////////
	// Read mux of stored bytes, unmapped index reads zero
	wire [7:0] rd_mux = (rd_addr == aircr_pkg::REG_INPUT_GAIN) ? in_reg_q :
		(rd_addr == aircr_pkg::REG_RATE_MODE) ? rate_reg_q : aircr_pkg::REG_RESET;

	// Control flops and restart pulse; the pulse lands with the new controls
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ctrl_q <= CTRL_RESET;
			commit_dly_q <= 1'b0;
			filter_restart <= 1'b0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			commit_dly_q <= wr_commit;
			filter_restart <= commit_dly_q;
		end
	end

	// Read answer flops; the byte stands until the next read
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_data_q <= aircr_pkg::REG_RESET;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_req;
			if (rd_req)
			begin
				rd_data_q <= rd_mux;
			end
		end
	end

	assign ctrl = ctrl_q;
	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;

endmodule : aircr_regs

// ### testbench/aircr_regs_assertions.sv
// Concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module aircr_regs_assertions (
	input wire logic sys_clk, // Clock
	input wire logic sys_rst, // Reset, active high
	input wire logic wr_stage, // Stage pulse
	input wire logic [1:0] wr_addr, // Stage index
	input wire logic [7:0] wr_data, // Stage byte
	input wire logic wr_commit, // Commit pulse
	input wire logic rd_req, // Read pulse
	input wire logic [1:0] rd_addr, // Read index
	input wire logic [7:0] rd_data, // Read byte
	input wire logic rd_valid, // Read strobe
	input aircr_pkg::aircr_ctrl_s ctrl, // Decoded controls
	input wire logic filter_restart // Restart pulse
);
	////////////////////////////////////////////////////////////////
	// Every check runs on the one clock and rests during reset
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	a_read_answer: assert property (rd_req |=> rd_valid)
		else $error("read not answered next cycle");
	a_read_quiet: assert property (!rd_req |=> !rd_valid && $stable(rd_data))
		else $error("read byte moved without a read");
	a_restart_delay: assert property (wr_commit |-> ##2 filter_restart)
		else $error("no restart two cycles after commit");
	a_restart_cause: assert property (filter_restart |-> $past(wr_commit, 2))
		else $error("restart without commit");
	a_ctrl_commit: assert property ($changed(ctrl) |-> $past(wr_commit, 2))
		else $error("controls moved without commit");
	a_bypass_gain: assert property (ctrl.amp_bypass_eff |-> ctrl.gain_log2 <= aircr_pkg::GAIN_MAX_BYPASS)
		else $error("amplifier bypassed at high gain");
	a_temp_force: assert property (ctrl.temp_sensor_enable |-> ctrl.ref_internal_forced && ctrl.gain_log2 == 3'h0
		&& !ctrl.amp_bypass_eff)
		else $error("temperature mode did not force controls");
	a_mode_clock: assert property (ctrl.mod_clk_fast == (ctrl.mode == aircr_pkg::AIRCR_TURBO)
		&& ctrl.duty_cycle == (ctrl.mode == aircr_pkg::AIRCR_DUTY))
		else $error("mode decode mismatch");
endmodule : aircr_regs_assertions
////////////////////////////////////////////////////////////////
bind aircr_regs aircr_regs_assertions u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_stage(wr_stage),
	.wr_addr(wr_addr), .wr_data(wr_data), .wr_commit(wr_commit), .rd_req(rd_req), .rd_addr(rd_addr),
	.rd_data(rd_data), .rd_valid(rd_valid), .ctrl(ctrl), .filter_restart(filter_restart));

// ### testbench/aircr_regs_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module aircr_regs_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wr_stage = 1'b0;
	logic [1:0] wr_addr = 2'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_commit = 1'b0;
	logic rd_req = 1'b0;
	logic [1:0] rd_addr = 2'h0;
	logic [7:0] rd_data;
	logic rd_valid;
	logic filter_restart;
	aircr_pkg::aircr_ctrl_s ctrl;
	int n_fail = 0;
	int check_count = 0;
	// Clock at 100 MHz
	always #5 sys_clk = ~sys_clk;
	aircr_regs uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .wr_stage(wr_stage), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_commit(wr_commit), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
		.rd_valid(rd_valid), .ctrl(ctrl), .filter_restart(filter_restart));
	////////////////////////////////////////////////////////////////
	// Compare, drive and read helpers
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cfg(input logic [1:0] a, input logic [7:0] d, input logic c);
		@(posedge sys_clk);
		wr_stage <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		wr_commit <= c;
		@(posedge sys_clk);
		wr_stage <= 1'b0;
		wr_commit <= 1'b0;
	endtask : cfg
	// Commit and wait the one cycle for the controls and restart pulse
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		cfg(a, d, 1'b1);
		@(posedge sys_clk);
		#1;
		chk(filter_restart, 64'h1);
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		rd_req <= 1'b1;
		rd_addr <= a;
		@(posedge sys_clk);
		rd_req <= 1'b0;
		#1;
		chk(rd_valid, 64'h1);
		chk(rd_data, e);
	endtask : rd
	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
		chk(ctrl.neg_input, 64'h1);
		chk(ctrl.gain_log2, 64'h0);
		chk(ctrl.rate_centi_sps, 64'd2000);
		chk({ctrl.conversion_mode, ctrl.temp_sensor_enable, ctrl.burnout_source_enable, ctrl.amp_bypass_eff}, 64'h0);
	endtask : t_reset
	task automatic t_stage();
		cfg(2'h1, 8'h14, 1'b0);
		rd(2'h1, 8'h00);
		wr(2'h1, 8'h14);
		chk(ctrl.mode, aircr_pkg::AIRCR_TURBO);
		chk(ctrl.conversion_mode, 64'h1);
		cfg(2'h0, 8'hA5, 1'b0);
		wr(2'h1, 8'h59);
		rd(2'h0, 8'hA5);
		rd(2'h1, 8'h59);
		chk(ctrl.neg_input, aircr_pkg::NEG_GROUND);
		chk(ctrl.rate_code, 64'h2);
		chk(ctrl.burnout_source_enable, 64'h1);
		wr(2'h2, 8'hFF);
		rd(2'h2, 8'h00);
	endtask : t_stage
	task automatic t_gain();
		for (int i = 0; i < 16; i++)
		begin
			wr(2'h0, {4'h0, i[2:0], i[3]});
			chk(ctrl.gain_log2, i[2:0]);
			chk(ctrl.amp_bypass_eff, i[3] && i[2:0] <= 2);
		end
	endtask : t_gain
	task automatic t_mode();
		for (int m = 0; m < 4; m++)
		begin
			wr(2'h1, {3'h5, m[1:0], 3'h4});
			chk(ctrl.mode, m);
			chk(ctrl.mod_clk_fast, m == 2);
			chk(ctrl.duty_cycle, m == 1);
			chk(ctrl.rate_centi_sps, (m == 0) ? 64'd60000 : (m == 1) ? 64'd15000 : (m == 2) ? 64'd120000 : 64'd0);
			chk(ctrl.rate_code, 64'h5);
		end
	endtask : t_mode
	task automatic t_temp();
		wr(2'h0, 8'hF7);
		chk(ctrl.sel_reserved, 64'h1);
		wr(2'h1, 8'h02);
		chk(ctrl.temp_sensor_enable, 64'h1);
		chk(ctrl.gain_log2, 64'h0);
		chk(ctrl.ref_internal_forced, 64'h1);
		rd(2'h0, 8'hF7);
	endtask : t_temp
	task automatic t_rerun();
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(2'h0, 8'h00);
		rd(2'h1, 8'h00);
	endtask : t_rerun
	task automatic finish_test();
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Main sequence
	initial
	begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_stage();
		t_gain();
		t_mode();
		t_temp();
		t_rerun();
		finish_test();
	end
endmodule : aircr_regs_tb
